// File: fsrc_core.sv
// Suspend and resume control of the program and erase sequencer of a serial NOR flash.
// Assumes the serial front end delivers each complete opcode with its address as one
// pulse on cmd_valid, and that command bytes are synchronous to mclk.
// Functional notes
// R1: While suspended, accept reset-enable 66H, reset 99H and no-operation 00H.
// R2: While suspended, also accept status interrupt 25H and wake signature ABH.
// R3: Allow page program of unprotected memory while an erase is suspended.
// R4: Refuse page program into the suspended erase's sector or block.
// R5: Host sends write enable before every page program, also during erase suspend.
// R6: A program inside erase suspend cannot be suspended; host lets it finish.
// R7: That program shows latch and busy as 1, both clear at completion.
// R8: Erase suspend flag is status bit 15, program suspend flag is bit 10.
// R9: Resume restarts whichever program or erase is suspended.
// R10: Host checks no page program runs before resuming an erase.
// R11: On resume, latch and busy go to 1 and the suspend flag clears.
// R12: Resumed operation runs until it finishes or another suspend arrives.
// R13: Host waits the resume-to-suspend time before another suspend.
// R14: Resume with no suspend flag set is ignored, status unchanged.
`timescale 1ns/1ns
module fsrc_core
	import fsrc_pkg::*;
#(
	parameter int PROG_CNT = fsrc_pkg::PROG_CYCLES,
	parameter int ERASE_CNT = fsrc_pkg::ERASE_CYCLES
) (
	// Clock and reset.
	input wire logic mclk,
	input wire logic reset_n,
	// Decoded commands from the serial front end.
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_code,
	input wire logic [fsrc_pkg::ADDR_W-1:0] cmd_addr,
	input wire logic addr_protected,
	// Software register port.
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// Status and events.
	output logic [15:0] status_word,
	output logic cmd_accepted,
	output logic cmd_refused,
	output logic soft_reset,
	output logic irq
);
	import fsrc_pkg::*;

	typedef enum logic [2:0] {ST_IDLE, ST_BUSY, ST_SUSPENDED, ST_NEST_PROG} fsrc_state_t;

	fsrc_state_t state_reg, state_next;
	fsrc_op_t op_reg;
	logic [ADDR_W-1:0] op_addr_reg;
	logic wel_reg, wel_next;
	logic reset_armed_reg;
	logic [1:0] config_reg;
	logic [15:0] accept_cnt_reg;
	logic main_load, nest_load, main_running, nest_running, main_done, nest_done;
	logic [EV_N-1:0] irq_status, irq_mask;
	logic irq_int;

	// Opcode classes.
	wire is_latch_set = cmd_code == CMD_WRITE_ENABLE;
	wire is_latch_clear = cmd_code == CMD_WRITE_DISABLE;
	wire is_pp = (cmd_code == CMD_PAGE_PROGRAM) || (cmd_code == CMD_PAGE_PROGRAM_DUAL)
		|| (cmd_code == CMD_PAGE_PROGRAM_QUAD);
	wire is_se = cmd_code == CMD_SECTOR_ERASE;
	wire is_be = cmd_code == CMD_BLOCK_ERASE;
	wire is_resume = (cmd_code == CMD_RESUME_A) || (cmd_code == CMD_RESUME_B);
	wire is_suspend = (cmd_code == CMD_SUSPEND_A) || (cmd_code == CMD_SUSPEND_B);
	wire is_arm = cmd_code == CMD_SOFT_RESET_ARM;
	wire is_rst = cmd_code == CMD_SOFT_RESET;
	wire is_no_op = cmd_code == CMD_NO_OPERATION;
	wire is_misc_ok = (cmd_code == CMD_STATUS_INTERRUPT) || (cmd_code == CMD_WAKE_SIGNATURE)
		|| (cmd_code == CMD_STATUS_LOW_READ) || (cmd_code == CMD_STATUS_HIGH_READ);

	// Suspend flags follow directly from state and the kind of suspended operation.
	wire suspended = (state_reg == ST_SUSPENDED) || (state_reg == ST_NEST_PROG);
	wire prog_susp = suspended && (op_reg == FSRC_OP_PROG); // R8
	wire erase_susp = suspended && (op_reg != FSRC_OP_PROG); // R8

	// Sector or block clash with the suspended erase.
	wire same_sector = cmd_addr[ADDR_W-1:SECTOR_LSB] == op_addr_reg[ADDR_W-1:SECTOR_LSB];
	wire same_block = cmd_addr[ADDR_W-1:BLOCK_LSB] == op_addr_reg[ADDR_W-1:BLOCK_LSB];
	wire erase_clash = (op_reg == FSRC_OP_SECT) ? same_sector : same_block; // R4

	// Commands legal in a suspend of either kind, outside a nested program.
	wire susp_common_ok = is_arm || is_rst || is_no_op || is_misc_ok // R1 R2
		|| is_latch_set || is_latch_clear;
	wire nested_pp_ok = (state_reg == ST_SUSPENDED) && erase_susp && is_pp && wel_reg
		&& !addr_protected && !erase_clash; // R3 R4 R5
	wire resume_ok = (state_reg == ST_SUSPENDED) && is_resume; // R9 R10 R14
	wire idle_start_ok = (state_reg == ST_IDLE) && wel_reg && !addr_protected
		&& (is_pp || is_se || is_be);
	wire suspend_ok = (state_reg == ST_BUSY) && is_suspend && !config_reg[0]; // R12

	// A command is refused when it is outside the set allowed in the present state.
	wire accept_now = cmd_valid && (
		(state_reg == ST_IDLE && (!(is_pp || is_se || is_be) || idle_start_ok)
			&& !is_suspend && !is_resume) ||
		(state_reg == ST_BUSY && (is_misc_ok || is_suspend && suspend_ok || is_rst || is_arm
			|| is_no_op)) ||
		(state_reg == ST_SUSPENDED && (susp_common_ok || nested_pp_ok || resume_ok)) ||
		(state_reg == ST_NEST_PROG && (is_misc_ok || is_rst || is_arm || is_no_op))); // R6
	wire refuse_now = cmd_valid && !accept_now;
	wire do_reset = cmd_valid && is_rst && reset_armed_reg;

	// Next state of the sequencer.
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (cmd_valid && idle_start_ok)
					state_next = ST_BUSY;
			end
			ST_BUSY: begin
				if (main_done)
					state_next = ST_IDLE;
				else if (cmd_valid && suspend_ok)
					state_next = ST_SUSPENDED; // R12
			end
			ST_SUSPENDED: begin
				if (cmd_valid && resume_ok)
					state_next = ST_BUSY; // R9
				else if (cmd_valid && nested_pp_ok)
					state_next = ST_NEST_PROG; // R3
			end
			ST_NEST_PROG: begin
				if (nest_done)
					state_next = ST_SUSPENDED; // R6
			end
			default: state_next = ST_IDLE;
		endcase
		if (do_reset)
			state_next = ST_IDLE;
	end

	// Write enable latch: set by write enable, operation start and resume, cleared by write disable, completion and soft reset.
	always_comb begin
		wel_next = wel_reg;
		if (cmd_valid && accept_now && is_latch_set)
			wel_next = 1'b1;
		else if (cmd_valid && accept_now && is_latch_clear)
			wel_next = 1'b0;
		if (cmd_valid && (idle_start_ok || nested_pp_ok))
			wel_next = 1'b1; // R7
		if (cmd_valid && resume_ok)
			wel_next = 1'b1; // R11
		if (main_done || nest_done)
			wel_next = 1'b0; // R7
		if (do_reset)
			wel_next = 1'b0;
	end

	wire wip_next = (state_next == ST_BUSY) || (state_next == ST_NEST_PROG); // R7 R11
	wire suspending = cmd_valid && suspend_ok && !main_done;
	assign main_load = cmd_valid && idle_start_ok;
	assign nest_load = cmd_valid && nested_pp_ok;
	wire main_hold = state_next != ST_BUSY;
	wire [EV_N-1:0] events = {suspending, cmd_valid && resume_ok, refuse_now,
		main_done || nest_done};
	wire [15:0] status_next = {erase_susp_n(state_next, op_reg, main_load), 4'h0,
		prog_susp_n(state_next, op_reg, main_load), 8'h00, wel_next, wip_next};

	// Suspend flag helpers use the next state so the flags move with the status.
	function automatic logic erase_susp_n(fsrc_state_t s, fsrc_op_t o, logic ld);
		erase_susp_n = (s == ST_SUSPENDED || s == ST_NEST_PROG) && o != FSRC_OP_PROG && !ld;
	endfunction
	function automatic logic prog_susp_n(fsrc_state_t s, fsrc_op_t o, logic ld);
		prog_susp_n = (s == ST_SUSPENDED || s == ST_NEST_PROG) && o == FSRC_OP_PROG && !ld;
	endfunction

	// Register read decode.
	wire [15:0] rd_mux =
		(reg_addr == OFF_STATUS) ? status_word :
		(reg_addr == OFF_IRQ_STAT) ? {12'h000, irq_status} :
		(reg_addr == OFF_IRQ_MASK) ? {12'h000, irq_mask} :
		(reg_addr == OFF_CONFIG) ? {14'h0000, config_reg} :
		(reg_addr == OFF_ACCEPT_CNT) ? accept_cnt_reg : 16'h0000;

	// Operation record, captured when an array operation starts from idle.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			op_reg <= FSRC_OP_PROG;
			op_addr_reg <= '0;
		end else if (main_load) begin
			op_reg <= is_pp ? FSRC_OP_PROG : (is_se ? FSRC_OP_SECT : FSRC_OP_BLOCK);
			op_addr_reg <= cmd_addr;
		end
	end

	// Sequencer state, latch and visible status.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= ST_IDLE;
			wel_reg <= 1'b0;
			status_word <= 16'h0000;
		end else begin
			state_reg <= state_next;
			wel_reg <= wel_next;
			status_word <= status_next; // R8 R11
		end
	end

	// Reset arming: any command other than the arm command 66H disarms it, the reset itself included.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			reset_armed_reg <= 1'b0;
		else if (cmd_valid)
			reset_armed_reg <= is_arm; // R1
	end

	// Command answer pulses and the software reset strobe.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			cmd_accepted <= 1'b0;
			cmd_refused <= 1'b0;
			soft_reset <= 1'b0;
		end else begin
			cmd_accepted <= accept_now;
			cmd_refused <= refuse_now; // R4
			soft_reset <= do_reset;
		end
	end

	// Software registers; the counter shows how many commands were accepted.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			config_reg <= CONFIG_RST;
			accept_cnt_reg <= 16'h0000;
			reg_rdata <= 16'h0000;
		end else begin
			if (reg_wr && reg_addr == OFF_CONFIG)
				config_reg <= reg_wdata[1:0];
			if (accept_now)
				accept_cnt_reg <= accept_cnt_reg + 16'h0001;
			reg_rdata <= reg_rd ? rd_mux : 16'h0000;
		end
	end

	// Main operation timer pauses while suspended and continues on resume.
	fsrc_op_timer #(.CNT_W(32)) main_timer (
		.mclk(mclk),
		.reset_n(reset_n),
		.load(main_load),
		.load_value(is_pp ? 32'(PROG_CNT) : 32'(ERASE_CNT)),
		.hold(main_hold), // R12
		.abort(do_reset),
		.running(main_running),
		.done(main_done)
	);

	// Nested program timer; nothing may hold it, so only a soft reset stops it before the end.
	fsrc_op_timer #(.CNT_W(32)) nest_timer (
		.mclk(mclk),
		.reset_n(reset_n),
		.load(nest_load),
		.load_value(32'(PROG_CNT)),
		.hold(1'b0), // R6
		.abort(do_reset),
		.running(nest_running),
		.done(nest_done)
	);

	// Interrupt status and mask.
	fsrc_irq #(.N(EV_N)) irq_unit (
		.mclk(mclk),
		.reset_n(reset_n),
		.events(events),
		.clear_wr(reg_wr && reg_addr == OFF_IRQ_STAT),
		.clear_bits(reg_wdata[EV_N-1:0]),
		.mask_wr(reg_wr && reg_addr == OFF_IRQ_MASK),
		.mask_data(reg_wdata[EV_N-1:0]),
		.status(irq_status),
		.mask(irq_mask),
		.irq(irq_int)
	);
	assign irq = irq_int;

	// Checks on the suspend and resume behaviour.
	sequence s_resume_taken;
		cmd_valid && resume_ok && !do_reset;
	endsequence
	sequence s_status_resumed;
		status_word[STAT_LATCH_BIT] && status_word[STAT_BUSY_BIT]
			&& !status_word[STAT_ESUS_BIT] && !status_word[STAT_PSUS_BIT];
	endsequence

	resume_sets_busy_a: assert property (@(posedge mclk) disable iff (!reset_n) // R11
		s_resume_taken |=> s_status_resumed) else $error("resume did not set busy");
	resume_restarts_a: assert property (@(posedge mclk) disable iff (!reset_n) // R9
		s_resume_taken |=> state_reg == ST_BUSY) else $error("resume did not restart");
	idle_resume_ignored_a: assert property (@(posedge mclk) disable iff (!reset_n) // R14
		cmd_valid && is_resume && !suspended |=> $stable(status_word[15:10]))
		else $error("resume without suspend changed flags");
	suspend_basic_ok_a: assert property (@(posedge mclk) disable iff (!reset_n) // R1
		cmd_valid && suspended && (is_arm || is_rst || is_no_op) |=> cmd_accepted)
		else $error("basic command refused in suspend");
	suspend_misc_ok_a: assert property (@(posedge mclk) disable iff (!reset_n) // R2
		cmd_valid && suspended && is_misc_ok |=> cmd_accepted)
		else $error("status or wake command refused in suspend");
	nested_pp_ok_a: assert property (@(posedge mclk) disable iff (!reset_n) // R3
		cmd_valid && state_reg == ST_SUSPENDED && erase_susp && is_pp && wel_reg
		&& !addr_protected && !erase_clash && !do_reset |=> state_reg == ST_NEST_PROG)
		else $error("allowed program during erase suspend not started");
	clash_refused_a: assert property (@(posedge mclk) disable iff (!reset_n) // R4
		cmd_valid && erase_susp && is_pp && erase_clash && !nest_done |=> cmd_refused
		&& $stable(state_reg)) else $error("program into suspended area accepted");
	nested_busy_a: assert property (@(posedge mclk) disable iff (!reset_n) // R7
		state_reg == ST_NEST_PROG && !nest_done && !do_reset |=> status_word[STAT_LATCH_BIT]
		&& status_word[STAT_BUSY_BIT]) else $error("nested program not shown busy");
	nested_done_a: assert property (@(posedge mclk) disable iff (!reset_n) // R7
		nest_done && !do_reset |=> !status_word[STAT_LATCH_BIT] && !status_word[STAT_BUSY_BIT]
		&& status_word[STAT_ESUS_BIT]) else $error("nested program end not reported");
	nested_unsusp_a: assert property (@(posedge mclk) disable iff (!reset_n) // R6
		state_reg == ST_NEST_PROG && cmd_valid && is_suspend |=> cmd_refused)
		else $error("nested program was suspended");
	flag_bits_a: assert property (@(posedge mclk) disable iff (!reset_n) // R8
		state_reg == ST_SUSPENDED && $stable(state_reg) |-> status_word[STAT_ESUS_BIT]
		== (op_reg != FSRC_OP_PROG) && status_word[STAT_PSUS_BIT] == (op_reg == FSRC_OP_PROG))
		else $error("suspend flags wrong");
	resumed_runs_a: assert property (@(posedge mclk) disable iff (!reset_n) // R12
		state_reg == ST_BUSY && !main_done && !(cmd_valid && (is_suspend || is_rst))
		|=> state_reg == ST_BUSY) else $error("resumed operation stopped early");
endmodule

// File: fsrc_pkg.sv
// Constants shared by the suspend and resume control of the flash sequencer.
// Assumes command bytes arrive already decoded from the serial link as whole opcodes.
package fsrc_pkg;
	// Command opcodes that matter to suspend handling.
	localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] CMD_STATUS_LOW_READ = 8'h05;
	localparam logic [7:0] CMD_STATUS_HIGH_READ = 8'h35;
	localparam logic [7:0] CMD_STATUS_INTERRUPT = 8'h25;
	localparam logic [7:0] CMD_WAKE_SIGNATURE = 8'hab;
	localparam logic [7:0] CMD_SOFT_RESET_ARM = 8'h66;
	localparam logic [7:0] CMD_SOFT_RESET = 8'h99;
	localparam logic [7:0] CMD_NO_OPERATION = 8'h00;
	localparam logic [7:0] CMD_RESUME_A = 8'h7a;
	localparam logic [7:0] CMD_RESUME_B = 8'h30;
	localparam logic [7:0] CMD_SUSPEND_A = 8'h75;
	localparam logic [7:0] CMD_SUSPEND_B = 8'hb0;
	localparam logic [7:0] CMD_PAGE_PROGRAM = 8'h02;
	localparam logic [7:0] CMD_PAGE_PROGRAM_DUAL = 8'ha2;
	localparam logic [7:0] CMD_PAGE_PROGRAM_QUAD = 8'h32;
	localparam logic [7:0] CMD_SECTOR_ERASE = 8'h20;
	localparam logic [7:0] CMD_BLOCK_ERASE = 8'hd8;
	// Status bit positions in the sixteen-bit status word.
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_LATCH_BIT = 1;
	localparam int STAT_PSUS_BIT = 10;
	localparam int STAT_ESUS_BIT = 15;
	// Address geometry.
	localparam int ADDR_W = 24;
	localparam int SECTOR_LSB = 12;
	localparam int BLOCK_LSB = 16;
	// Register map offsets of the software port.
	localparam logic [3:0] OFF_STATUS = 4'h0;
	localparam logic [3:0] OFF_IRQ_STAT = 4'h1;
	localparam logic [3:0] OFF_IRQ_MASK = 4'h2;
	localparam logic [3:0] OFF_CONFIG = 4'h3;
	localparam logic [3:0] OFF_ACCEPT_CNT = 4'h4;
	// Interrupt event bit positions.
	localparam int EV_DONE = 0;
	localparam int EV_REFUSE = 1;
	localparam int EV_RESUME = 2;
	localparam int EV_SUSPEND = 3;
	localparam int EV_N = 4;
	// Reset values.
	localparam logic [EV_N-1:0] IRQ_MASK_RST = 4'h0;
	localparam logic [1:0] CONFIG_RST = 2'h0;
	// Timing of the array operations at a 50 MHz mclk.
	localparam int MCLK_MHZ = 50;
	localparam int PROG_TIME_US = 500;
	localparam int ERASE_TIME_US = 60000;
	localparam int PROG_CYCLES = PROG_TIME_US * MCLK_MHZ;
	localparam int ERASE_CYCLES = ERASE_TIME_US * MCLK_MHZ;
	// Operation kinds.
	typedef enum logic [1:0] {FSRC_OP_PROG, FSRC_OP_SECT, FSRC_OP_BLOCK} fsrc_op_t;
endpackage

// File: fsrc_op_timer.sv
// Busy timer for one array operation that can be paused and continued.
// Assumes start, hold and load never coincide with reset release hazards; single mclk.
`timescale 1ns/1ns
module fsrc_op_timer #(
	parameter int CNT_W = 32
) (
	// Clock and reset.
	input wire logic mclk,
	input wire logic reset_n,
	// Control.
	input wire logic load,
	input wire logic [CNT_W-1:0] load_value,
	input wire logic hold,
	input wire logic abort,
	// Status.
	output logic running,
	output logic done
);
	logic [CNT_W-1:0] count_reg;
	wire counting = (count_reg != '0) && !hold;

	// Counter keeps its value while paused, so a resumed operation finishes the remainder.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			count_reg <= '0;
			done <= 1'b0;
		end else begin
			done <= counting && (count_reg == {{(CNT_W-1){1'b0}}, 1'b1}) && !abort && !load;
			if (abort)
				count_reg <= '0;
			else if (load)
				count_reg <= load_value;
			else if (counting)
				count_reg <= count_reg - 1'b1;
		end
	end

	assign running = (count_reg != '0);
endmodule

// File: fsrc_irq.sv
// Sticky interrupt status with write-one-to-clear and a mask onto one level output.
// Assumes events are one-cycle pulses in the mclk domain.
`timescale 1ns/1ns
module fsrc_irq #(
	parameter int N = 4
) (
	// Clock and reset.
	input wire logic mclk,
	input wire logic reset_n,
	// Events and software access.
	input wire logic [N-1:0] events,
	input wire logic clear_wr,
	input wire logic [N-1:0] clear_bits,
	input wire logic mask_wr,
	input wire logic [N-1:0] mask_data,
	// Results.
	output logic [N-1:0] status,
	output logic [N-1:0] mask,
	output logic irq
);
	// A set arriving in the clearing cycle wins so that no event is lost.
	wire [N-1:0] status_next = (status & ~(clear_wr ? clear_bits : '0)) | events;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			status <= '0;
			mask <= '0;
			irq <= 1'b0;
		end else begin
			status <= status_next;
			if (mask_wr)
				mask <= mask_data;
			irq <= |(status_next & (mask_wr ? mask_data : mask));
		end
	end
endmodule

// File: fsrc_host.sv
// Host side model that issues decoded commands to the suspend control, one at a time.
// Assumes a single mclk and that the testbench calls its tasks from one process.
`timescale 1ns/1ns
module fsrc_host #(
	parameter int GAP = 4
) (
	// Clock and the status word seen by the host.
	mclk,
	status_word,
	// Decoded command lines.
	cmd_valid,
	cmd_code,
	cmd_addr
);
	import fsrc_pkg::*;
	input wire logic mclk;
	input wire logic [15:0] status_word;
	output logic cmd_valid = 1'b0;
	output logic [7:0] cmd_code = 8'h00;
	output logic [fsrc_pkg::ADDR_W-1:0] cmd_addr = 24'h000000;
	int cyc = 0;
	int last_resume = 0;

	// Free running cycle count, used to space a suspend after a resume.
	always @(posedge mclk) begin
		cyc <= cyc + 1;
	end

	// One command pulse. Idle lines carry the inverse so stale values never look valid.
	task automatic send(input logic [7:0] code, input logic [23:0] addr);
		@(posedge mclk);
		cmd_valid <= 1'b1;
		cmd_code <= code;
		cmd_addr <= addr;
		@(posedge mclk);
		cmd_valid <= 1'b0;
		cmd_code <= ~code;
		cmd_addr <= ~addr;
		if (code == CMD_RESUME_A || code == CMD_RESUME_B) begin
			last_resume = cyc;
		end
		#1;
	endtask

	// Every program or erase is preceded by a write enable.
	task automatic start_op(input logic [7:0] code, input logic [23:0] addr);
		send(CMD_WRITE_ENABLE, 24'h000000);
		send(code, addr);
	endtask

	// A running program is given up to 200 cycles to finish before any resume is sent.
	task automatic resume(input logic [7:0] code);
		for (int i = 0; i < 200 && status_word[0] === 1'b1; i++) begin
			@(posedge mclk);
		end
		send(code, 24'h000000);
	endtask

	// A suspend keeps its distance from the last resume.
	task automatic suspend(input logic [7:0] code);
		while (cyc - last_resume < GAP) begin
			@(posedge mclk);
		end
		send(code, 24'h000000);
	endtask
endmodule

// File: fsrc_core_tb.sv
// Self-checking testbench of the suspend and resume control.
// Assumes the host model drives the command port and this module the register port.
`timescale 1ns/1ns
module fsrc_core_tb;
	import fsrc_pkg::*;
	localparam int PROG_N = 8;
	localparam int ERASE_N = 20;
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	logic cmd_valid;
	logic [7:0] cmd_code;
	logic [23:0] cmd_addr;
	logic addr_protected = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:0] reg_rdata;
	logic [15:0] status_word;
	logic [15:0] d;
	logic cmd_accepted;
	logic cmd_refused;
	logic soft_reset;
	logic irq;
	int errors = 0;
	int check_count = 0;
	int n;
	// Opcode beside whether a suspended device takes it; the same for both suspend kinds.
	logic [8:0] rows [12] = '{{8'h66, 1'b1}, {8'h00, 1'b1}, {8'h25, 1'b1}, {8'hab, 1'b1},
		{8'h05, 1'b1}, {8'h35, 1'b1}, {8'h06, 1'b1}, {8'h04, 1'b1}, {8'h99, 1'b1},
		{8'hd8, 1'b0}, {8'h75, 1'b0}, {8'h20, 1'b0}};

	// Small counts keep the array operations short in simulation.
	fsrc_core #(.PROG_CNT(PROG_N), .ERASE_CNT(ERASE_N)) fsrc_core_inst (.mclk(mclk),
		.reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_addr(cmd_addr),
		.addr_protected(addr_protected), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .status_word(status_word),
		.cmd_accepted(cmd_accepted), .cmd_refused(cmd_refused), .soft_reset(soft_reset),
		.irq(irq));
	fsrc_host #(.GAP(4)) fsrc_host_inst (.mclk(mclk), .status_word(status_word),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_addr(cmd_addr));

	// Clock of 20 ns.
	always #10 mclk = ~mclk;

	// Verdict and end of run.
	task automatic conclude();
		if (errors == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Compare with case equality so an unknown never passes.
	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string msg);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t ns: %s got %h want %h", $time, msg, got, exp);
		end
	endtask

	// Answer pulse of the last command and the masked status word.
	task automatic expect_ans(input logic ok, input logic [15:0] m, input logic [15:0] v,
		input string msg);
		check(16'({cmd_accepted, cmd_refused}), 16'({ok, ~ok}), msg);
		check(status_word & m, v, msg);
	endtask

	task automatic run_rows(input logic [15:0] flags);
		for (int i = 0; i < 12; i++) begin
			fsrc_host_inst.send(rows[i][8:1], 24'h000000);
			expect_ans(rows[i][0], 16'h8400, flags, "suspend command set");
		end
	endtask

	task automatic wait_idle(input int lim, output int cnt);
		cnt = 0;
		while (status_word[0] !== 1'b0 && cnt < lim) begin
			@(posedge mclk);
			#1;
			cnt++;
		end
		check(16'(cnt < lim), 16'h0001, "busy never cleared");
	endtask

	task automatic reg_write(input logic [3:0] a, input logic [15:0] v);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask

	task automatic reg_read(input logic [3:0] a, output logic [15:0] v);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		v = reg_rdata;
	endtask

	task automatic irq_is(input logic v, input string msg);
		repeat (2) @(posedge mclk);
		#1;
		check(16'(irq), 16'(v), msg);
	endtask

	// Watchdog, well beyond the few hundred cycles that the tests need.
	initial begin
		#(20 * 5000);
		errors++;
		$display("unexpected at %0t ns: watchdog expired", $time);
		conclude();
	end

	// Main sequence: reset, the table, then the hand-written cases.
	initial begin
		repeat (10) @(posedge mclk);
		#1;
		check(16'({cmd_accepted, cmd_refused, soft_reset, irq}), 16'h0000, "reset outputs");
		check(status_word | reg_rdata, 16'h0000, "reset status");
		repeat (10) @(posedge mclk);
		reset_n <= 1'b1;
		fsrc_host_inst.start_op(CMD_SECTOR_ERASE, 24'h001000);
		fsrc_host_inst.suspend(CMD_SUSPEND_B);
		expect_ans(1'b1, 16'h8400, 16'h8000, "sector erase suspend");
		run_rows(16'h8000);
		fsrc_host_inst.start_op(CMD_PAGE_PROGRAM, 24'h001abc);
		expect_ans(1'b0, 16'h8400, 16'h8000, "program in suspended sector");
		@(posedge mclk) addr_protected <= 1'b1;
		fsrc_host_inst.start_op(CMD_PAGE_PROGRAM_DUAL, 24'h005000);
		expect_ans(1'b0, 16'h8400, 16'h8000, "program to protected place");
		@(posedge mclk) addr_protected <= 1'b0;
		fsrc_host_inst.start_op(CMD_PAGE_PROGRAM_QUAD, 24'h005000);
		expect_ans(1'b1, 16'h8403, 16'h8003, "program inside erase suspend");
		fsrc_host_inst.send(CMD_SUSPEND_A, 24'h000000);
		expect_ans(1'b0, 16'h8403, 16'h8003, "suspend of nested program");
		fsrc_host_inst.send(CMD_RESUME_A, 24'h000000);
		expect_ans(1'b0, 16'h8403, 16'h8003, "resume during nested program");
		wait_idle(PROG_N + 8, n);
		check(status_word & 16'h8403, 16'h8000, "nested program done");
		fsrc_host_inst.resume(CMD_RESUME_A);
		expect_ans(1'b1, 16'h8403, 16'h0003, "erase resumed");
		wait_idle(ERASE_N + 8, n);
		// Block erase: refusal in its block, then resume and a second suspend.
		fsrc_host_inst.start_op(CMD_BLOCK_ERASE, 24'h030000);
		fsrc_host_inst.suspend(CMD_SUSPEND_A);
		expect_ans(1'b1, 16'h8400, 16'h8000, "block erase suspend");
		fsrc_host_inst.start_op(CMD_PAGE_PROGRAM, 24'h03f000);
		expect_ans(1'b0, 16'h8400, 16'h8000, "program in suspended block");
		fsrc_host_inst.resume(CMD_RESUME_B);
		expect_ans(1'b1, 16'h8403, 16'h0003, "block erase resumed");
		fsrc_host_inst.suspend(CMD_SUSPEND_B);
		expect_ans(1'b1, 16'h8400, 16'h8000, "suspend after resume");
		fsrc_host_inst.resume(CMD_RESUME_A);
		expect_ans(1'b1, 16'h8403, 16'h0003, "block erase resumed again");
		wait_idle(ERASE_N + 8, n);
		// Program suspend: no programming inside it.
		fsrc_host_inst.start_op(CMD_PAGE_PROGRAM, 24'h010000);
		fsrc_host_inst.suspend(CMD_SUSPEND_A);
		expect_ans(1'b1, 16'h8400, 16'h0400, "program suspend");
		run_rows(16'h0400);
		fsrc_host_inst.start_op(CMD_PAGE_PROGRAM, 24'h020000);
		expect_ans(1'b0, 16'h8400, 16'h0400, "program in program suspend");
		fsrc_host_inst.resume(CMD_RESUME_B);
		expect_ans(1'b1, 16'h8403, 16'h0403 & 16'h8003, "program resumed");
		wait_idle(PROG_N + 8, n);
		check(status_word & 16'h8403, 16'h0000, "program finished");
		d = status_word;
		fsrc_host_inst.send(CMD_RESUME_A, 24'h000000);
		expect_ans(1'b0, 16'hffff, d, "resume with nothing suspended");
		fsrc_host_inst.send(CMD_SOFT_RESET_ARM, 24'h000000);
		fsrc_host_inst.send(CMD_SOFT_RESET, 24'h000000);
		check(16'({cmd_accepted, soft_reset}), 16'h0003, "soft reset pulse");
		// Configuration bit 0 blocks suspend, so a running program refuses it.
		reg_write(OFF_CONFIG, 16'h0001);
		reg_read(OFF_CONFIG, d);
		check(d, 16'h0001, "config readback");
		fsrc_host_inst.start_op(CMD_PAGE_PROGRAM, 24'h040000);
		fsrc_host_inst.send(CMD_SUSPEND_B, 24'h000000);
		expect_ans(1'b0, 16'h8403, 16'h0003, "suspend blocked by config");
		wait_idle(PROG_N + 8, n);
		reg_write(OFF_CONFIG, 16'h0000);
		// One accepted command moves the counter by one.
		reg_read(OFF_ACCEPT_CNT, d);
		fsrc_host_inst.send(CMD_NO_OPERATION, 24'h000000);
		reg_read(OFF_ACCEPT_CNT, n);
		check(16'(n), d + 16'h0001, "accept counter");
		// Interrupt raise, mask and clear through the register port.
		reg_read(OFF_IRQ_STAT, d);
		check(d, 16'h000f, "all events seen");
		reg_write(OFF_IRQ_STAT, 16'h000f);
		reg_write(OFF_IRQ_MASK, 16'h0002);
		reg_read(OFF_IRQ_MASK, d);
		check(d, 16'h0002, "mask readback");
		irq_is(1'b0, "irq idle");
		fsrc_host_inst.send(CMD_RESUME_B, 24'h000000);
		irq_is(1'b1, "irq raised");
		reg_read(OFF_IRQ_STAT, d);
		check(d & 16'h0002, 16'h0002, "refusal event");
		reg_write(OFF_IRQ_MASK, 16'h0000);
		irq_is(1'b0, "irq masked");
		reg_write(OFF_IRQ_MASK, 16'h0002);
		irq_is(1'b1, "irq unmasked");
		reg_write(OFF_IRQ_STAT, 16'h0002);
		irq_is(1'b0, "irq cleared");
		reg_write(OFF_STATUS, 16'hffff);
		reg_read(OFF_STATUS, d);
		check(d, 16'h0000, "status read only");
		reg_read(4'hf, d);
		check(d, 16'h0000, "unmapped read");
		conclude();
	end
endmodule
